// >>> hw/rscd_reset_ctrl.sv
// reset sources, cause flags, flash stretch and clock stop detector
// Function
// (R1) reset pin low for twelve high clock periods applies reset
// (R2) after release stretch, fetch starts from vector at top two bytes
// (R3) fetch from special area, display buffer, or trapped RAM resets
// (R4) illegal oscillator enable clears cause system clock reset
// (R5) system clock and clock stop resets are followed by flash stretch
// (R6) each internal reset sets its own cause flag
// (R7) flag clear write of one or pin reset clears all cause flags
// (R8) flag clear bit always reads back zero
// (R9) cause flags survive internal resets
// (R10) detector holds reset while ratio is outside bounds
// (R11) enable code turns detection on, zero code turns it off
// (R12) enable accepted only from zero with both oscillators on
// (R13) high oscillator off or low power entry clears detector control
// (R14) detector control survives internal resets
// (R15) low oscillator keeps running while detection is on
// (R16) bound writes are dropped while detection is on
// (R17) bound registers survive internal resets
// (R18) bounds compare against the ratio divided by four
// (R19) software programs lower below upper and enables when stable
// (R20) reset asserts after two further low clock rising edges
// (R21) measurement keeps running during the detector reset
// (R22) stopped low clock gives no reset until it resumes
// (R23) flash stretch lasts two to the tenth high clock periods
// (R24) malfunction reset applied within twenty-four high clock periods
// (R25) reset output combines sources, stretched, released on clock
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rscd_reset_ctrl #(
	parameter logic [15:0] SFR_LO = 16'h0000,
	parameter logic [15:0] SFR_HI = 16'h003f,
	parameter logic [15:0] DBR_LO = 16'h0f80,
	parameter logic [15:0] DBR_HI = 16'h0fff,
	parameter logic [15:0] RAM_LO = 16'h0040,
	parameter logic [15:0] RAM_HI = 16'h083f
) (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   nrst,
	// axi4-lite write
	input  wire logic [rscd_pkg::AXI_AW-1:0] awaddr,
	input  wire logic                   awvalid,
	output logic                        awready,
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	input  wire logic                   wvalid,
	output logic                        wready,
	output logic [1:0]                  bresp,
	output logic                        bvalid,
	input  wire logic                   bready,
	// axi4-lite read
	input  wire logic [rscd_pkg::AXI_AW-1:0] araddr,
	input  wire logic                   arvalid,
	output logic                        arready,
	output logic [31:0]                 rdata,
	output logic [1:0]                  rresp,
	output logic                        rvalid,
	input  wire logic                   rready,
	// pins
	input  wire logic                   resetPinN,
	input  wire logic                   lowClkPin,
	// core side
	input  wire logic                   fetchValid,
	input  wire logic [15:0]            fetchAddr,
	input  wire logic                   wdResetReq,
	input  wire logic                   lowPowerEnter,
	output logic                        cpuReset,
	output logic                        bootFetch,
	output logic [15:0]                 bootAddr,
	output logic                        highOscEn,
	output logic                        lowOscEn,
	output logic                        sysClkSel
);
	import rscd_pkg::*;

	logic [2:0]        pinSync;
	logic [2:0]        lowSync;
	logic              pinSt;
	logic              lowSt;
	logic              lowPrev;
	logic [3:0]        lowCnt;
	logic              awHave;
	logic              wHave;
	logic [AXI_AW-1:0] awAddrQ;
	logic [7:0]        wDataQ;
	logic              wStrbQ;
	logic [3:0]        flags;
	logic [7:0]        ctrl;
	logic [7:0]        lower;
	logic [7:0]        upper;
	logic              xen;
	logic              low_osc_enable;
	logic              sysck;
	logic              ram_trap_area_select;
	logic              armed;
	logic [RCNT_W-1:0] rcnt;
	rscd_stop_t        stopState;
	rscd_stop_t        next_stopState;
	logic [10:0]       stretchCnt;

	// three-stage synchronisers; a change counts when stages two and three agree
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pinSync <= 3'h7;
			lowSync <= 3'h0;
			pinSt   <= 1'b1;
			lowSt   <= 1'b0;
			lowPrev <= 1'b0;
		end else begin
			pinSync <= {pinSync[1:0], resetPinN};
			lowSync <= {lowSync[1:0], lowClkPin};
			if (pinSync[1] == pinSync[2])
				pinSt <= pinSync[2];
			if (lowSync[1] == lowSync[2])
				lowSt <= lowSync[2];
			lowPrev <= lowSt;
		end
	end

	wire lowEdge = lowSt & ~lowPrev;

	// pin reset takes effect only after a long enough low level
	wire extRst = (lowCnt == EXT_LOW_CYC); // R1
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			lowCnt <= 4'h0;
		else if (pinSt)
			lowCnt <= 4'h0;
		else if (!extRst)
			lowCnt <= lowCnt + 4'h1; // R1
	end

	// write channel: address and data taken in either order
	wire wrFire = awHave & wHave & ~bvalid;
	wire [11:0] wrIdx = awAddrQ[AXI_AW-1:2];
	wire wrByte = wrFire & wStrbQ;
	wire wrFlags = wrByte & (wrIdx == IDX_FLAGS);
	wire wrCtrl = wrByte & (wrIdx == IDX_CTRL);
	wire wrLower = wrByte & (wrIdx == IDX_LOWER);
	wire wrUpper = wrByte & (wrIdx == IDX_UPPER);
	wire wrSys = wrByte & (wrIdx == IDX_SYSCTL);
	wire wrHit = (wrIdx == IDX_FLAGS) | (wrIdx == IDX_CTRL)
		| (wrIdx == IDX_LOWER) | (wrIdx == IDX_UPPER)
		| (wrIdx == IDX_SYSCTL);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			awHave  <= 1'b0;
			wHave   <= 1'b0;
			awAddrQ <= '0;
			wDataQ  <= 8'h00;
			wStrbQ  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				awHave  <= 1'b1;
				awAddrQ <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				wHave  <= 1'b1;
				wDataQ <= wdata[7:0];
				wStrbQ <= wstrb[0];
			end
			if (wrFire) begin
				awHave <= 1'b0;
				wHave  <= 1'b0;
				bvalid <= 1'b1;
				bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// reset events
	wire inSfr = (fetchAddr >= SFR_LO) & (fetchAddr <= SFR_HI);
	wire inDbr = (fetchAddr >= DBR_LO) & (fetchAddr <= DBR_HI);
	wire inRam = (fetchAddr >= RAM_LO) & (fetchAddr <= RAM_HI);
	wire trapEv = fetchValid & (inSfr | inDbr | (inRam & ram_trap_area_select)); // R3

	wire newX = wDataQ[BIT_XEN];
	wire newT = wDataQ[BIT_LOW_OSC_ENABLE];
	wire bothClr = xen & low_osc_enable & ~newX & ~newT;
	wire xClr = xen & ~newX & ~sysck;
	wire tClr = low_osc_enable & ~newT & sysck;
	wire sysEv = wrSys & (bothClr | xClr | tClr); // R4
	wire stopEv = lowEdge & (stopState == CS_WAIT2);
	wire clkStopRst = (stopState == CS_RST);
	wire srcActive = extRst | trapEv | sysEv | wdResetReq
		| clkStopRst; // R25

	// oscillators keep running on a rejected enable write
	wire [7:0] next_sysctl = extRst ? SYSCTL_RST
		: (wrSys && !sysEv) ? wDataQ // R4
		: {xen, low_osc_enable, sysck, 4'h0, ram_trap_area_select};
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			xen   <= SYSCTL_RST[BIT_XEN];
			low_osc_enable  <= SYSCTL_RST[BIT_LOW_OSC_ENABLE];
			sysck <= SYSCTL_RST[BIT_SYSCK];
			ram_trap_area_select  <= SYSCTL_RST[BIT_RAM_TRAP_AREA_SELECT];
		end else begin
			xen   <= next_sysctl[BIT_XEN];
			low_osc_enable  <= next_sysctl[BIT_LOW_OSC_ENABLE];
			sysck <= next_sysctl[BIT_SYSCK];
			ram_trap_area_select  <= next_sysctl[BIT_RAM_TRAP_AREA_SELECT];
		end
	end

	// cause flags: a new event wins over a clear in the same cycle
	wire flagClr = extRst | (wrFlags & wDataQ[BIT_FLAG_CLEAR_STROBE]); // R7
	wire [3:0] flagSet = {sysEv, trapEv, wdResetReq, stopEv}; // R6
	wire [3:0] next_flags = (flagClr ? FLAGS_RST : flags) | flagSet;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			flags <= FLAGS_RST;
		else
			flags <= next_flags; // R9
	end

	// detector control; only the pin reset initialises it
	wire detectOn = (ctrl == CTRL_ON);
	wire ctrlOk = (ctrl == CTRL_OFF) & xen & low_osc_enable;
	wire [7:0] next_ctrl = extRst ? CTRL_OFF // R14
		: (!xen || lowPowerEnter) ? CTRL_OFF // R13
		: (wrCtrl && wDataQ == CTRL_OFF) ? CTRL_OFF // R11
		: (wrCtrl && wDataQ == CTRL_ON && ctrlOk) ? CTRL_ON // R12
		: ctrl;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			ctrl <= CTRL_OFF;
		else
			ctrl <= next_ctrl;
	end

	// bounds locked while detection runs
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lower <= LOWER_RST;
			upper <= UPPER_RST;
		end else if (extRst) begin
			lower <= LOWER_RST; // R17
			upper <= UPPER_RST; // R17
		end else if (!detectOn) begin
			if (wrLower)
				lower <= wDataQ; // R16
			if (wrUpper)
				upper <= wDataQ; // R16
		end
	end

	// ratio = high clocks per low period; not touched by the reset output
	wire rcntFull = &rcnt;
	wire [7:0] ratio = rcnt[RCNT_W-1:RATIO_SHIFT]; // R18
	wire outRange = armed & ((ratio < lower) | (ratio > upper)); // R10
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			armed <= 1'b0;
			rcnt  <= '0;
		end else if (!detectOn) begin
			armed <= 1'b0;
			rcnt  <= '0;
		end else if (lowEdge) begin
			armed <= 1'b1;
			rcnt  <= RCNT_W'(1); // R21
		end else if (!rcntFull) begin
			rcnt <= rcnt + RCNT_W'(1);
		end
	end

	// state moves only on low clock edges or when detection is off, so a dead low clock stays put
	always_comb begin
		next_stopState = stopState;
		case (stopState)
			CS_OK:
				if (lowEdge && outRange)
					next_stopState = CS_WAIT1; // R10
			CS_WAIT1:
				if (lowEdge)
					next_stopState = CS_WAIT2; // R20
			CS_WAIT2:
				if (lowEdge)
					next_stopState = CS_RST; // R22
			CS_RST:
				if (lowEdge && !outRange)
					next_stopState = CS_OK; // R10
			default:
				next_stopState = CS_OK;
		endcase
		if (!detectOn)
			next_stopState = CS_OK;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			stopState <= CS_OK;
		else
			stopState <= next_stopState;
	end

	// flash stretch; counter starts full so power-up also gets a stretch
	wire [10:0] next_stretch = srcActive ? STRETCH_CYC // R5
		: (stretchCnt != 11'h000) ? stretchCnt - 11'h001 // R23
		: 11'h000;
	wire next_cpuReset = srcActive | (stretchCnt > 11'h001); // R24
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stretchCnt <= STRETCH_CYC;
			cpuReset   <= 1'b1;
			bootFetch  <= 1'b0;
		end else begin
			stretchCnt <= next_stretch;
			cpuReset   <= next_cpuReset; // R25
			bootFetch  <= cpuReset & ~next_cpuReset; // R2
		end
	end

	// oscillator outputs
	wire next_lowRun = next_sysctl[BIT_LOW_OSC_ENABLE] | (next_ctrl == CTRL_ON);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			highOscEn <= SYSCTL_RST[BIT_XEN];
			lowOscEn  <= SYSCTL_RST[BIT_LOW_OSC_ENABLE];
			sysClkSel <= SYSCTL_RST[BIT_SYSCK];
			bootAddr  <= VECTOR_ADDR; // R2
		end else begin
			highOscEn <= next_sysctl[BIT_XEN];
			lowOscEn  <= next_lowRun; // R15
			sysClkSel <= next_sysctl[BIT_SYSCK];
			bootAddr  <= VECTOR_ADDR;
		end
	end

	// read channel: answer one cycle after the address is taken
	wire [11:0] rdIdx = araddr[AXI_AW-1:2];
	wire [7:0] flagsRd = {1'b0, 3'h0, flags}; // R8
	wire [7:0] sysRd = {xen, low_osc_enable, sysck, 4'h0, ram_trap_area_select};
	wire rdHit = (rdIdx == IDX_FLAGS) | (rdIdx == IDX_CTRL)
		| (rdIdx == IDX_LOWER) | (rdIdx == IDX_UPPER)
		| (rdIdx == IDX_SYSCTL);
	wire [7:0] rdByte = (rdIdx == IDX_FLAGS) ? flagsRd
		: (rdIdx == IDX_CTRL) ? ctrl
		: (rdIdx == IDX_LOWER) ? lower
		: (rdIdx == IDX_UPPER) ? upper
		: (rdIdx == IDX_SYSCTL) ? sysRd
		: 8'h00;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= {24'h00_0000, rdByte};
			rresp   <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_pin_reset_clears: assert property ( // R7
		extRst |=> cpuReset && ((flags & 4'he) == 4'h0 || $past(trapEv)
			|| $past(sysEv) || $past(wdResetReq)))
		else $error("pin reset did not reset and clear flags");
	a_trap_flag_set: assert property ( // R6
		trapEv |=> flags[BIT_TRAP_RESET_FLAG] && cpuReset)
		else $error("trap did not set flag and reset");
	a_sysclk_reset: assert property ( // R4
		sysEv |=> flags[BIT_SYSCLK_RESET_FLAG] && cpuReset && $stable(highOscEn))
		else $error("system clock reset misbehaved");
	a_ctrl_guard: assert property ( // R12
		(wrCtrl && wDataQ == CTRL_ON && !(xen && low_osc_enable) && ctrl == CTRL_OFF)
			|=> ctrl == CTRL_OFF)
		else $error("enable accepted without both oscillators");
	a_ctrl_clear_xen: assert property ( // R13
		(detectOn && !xen) |=> ctrl == CTRL_OFF)
		else $error("control not cleared with high oscillator off");
	a_bound_lock: assert property ( // R16
		(detectOn && (wrLower || wrUpper) && !extRst)
			|=> $stable(lower) && $stable(upper))
		else $error("bound changed while detection on");
	a_stop_two_edges: assert property ( // R20
		(stopState == CS_OK && lowEdge && outRange && detectOn)
			|=> stopState == CS_WAIT1 && !clkStopRst)
		else $error("clock stop reset came too early");
	a_stop_flag: assert property ( // R6
		stopEv && detectOn |=> clkStopRst && flags[BIT_CLOCK_STOP_RESET_FLAG])
		else $error("clock stop reset or flag missing");
	a_stretch_end: assert property ( // R23
		(!srcActive && stretchCnt == 11'h001) |=> !cpuReset ##1 bootFetch == 1'b0)
		else $error("stretch did not end on time");
	a_stretch_hold: assert property ( // R5
		(srcActive ##1 !srcActive) |-> cpuReset [*8])
		else $error("reset released without stretch");
	a_boot_pulse: assert property ( // R2
		$fell(cpuReset) |-> bootFetch && bootAddr == VECTOR_ADDR)
		else $error("boot fetch missing at release");
	a_low_osc_keep: assert property ( // R15
		detectOn |=> lowOscEn || $past(lowPowerEnter) || !$past(xen)
			|| $past(extRst)
			|| ($past(wrCtrl) && $past(wDataQ) == CTRL_OFF))
		else $error("low oscillator stopped while detecting");
endmodule
`default_nettype wire

// >>> hw/rscd_pkg.sv
// shared constants for the reset sources and clock stop detector
package rscd_pkg;
	// bus and register map (indices; byte address is index times four)
	localparam int         AXI_AW     = 14;
	localparam logic [11:0] IDX_FLAGS  = 12'hfb5;
	localparam logic [11:0] IDX_CTRL   = 12'hfb6;
	localparam logic [11:0] IDX_LOWER  = 12'hfb7;
	localparam logic [11:0] IDX_UPPER  = 12'hfb8;
	localparam logic [11:0] IDX_SYSCTL = 12'hfb9;
	// reset cause flag fields
	localparam int BIT_FLAG_CLEAR_STROBE   = 7;
	localparam int BIT_SYSCLK_RESET_FLAG = 3;
	localparam int BIT_TRAP_RESET_FLAG  = 2;
	localparam int BIT_WATCHDOG_RESET_FLAG   = 1;
	localparam int BIT_CLOCK_STOP_RESET_FLAG  = 0;
	// system control two fields
	localparam int BIT_XEN    = 7;
	localparam int BIT_LOW_OSC_ENABLE   = 6;
	localparam int BIT_SYSCK  = 5;
	localparam int BIT_RAM_TRAP_AREA_SELECT   = 0;
	// codes and reset values
	localparam logic [7:0] CTRL_ON    = 8'he4;
	localparam logic [7:0] CTRL_OFF   = 8'h00;
	localparam logic [7:0] UPPER_RST  = 8'hff;
	localparam logic [7:0] LOWER_RST  = 8'h00;
	localparam logic [7:0] SYSCTL_RST = 8'h80;
	localparam logic [3:0] FLAGS_RST  = 4'h0;
	localparam logic [15:0] VECTOR_ADDR = 16'hfffe;
	// ratio counter: bound units are the ratio divided by four
	localparam int RATIO_SHIFT = 2;
	localparam int RCNT_W      = 8 + RATIO_SHIFT;
	// timing, in high clock periods; clk is the high clock
	localparam int CLK_PER_FC  = 1;
	localparam int EXT_LOW_FC  = 12;
	localparam int STRETCH_FC  = 2 ** 10;
	localparam int MAL_MAX_FC  = 24;
	localparam logic [3:0]  EXT_LOW_CYC = 4'(EXT_LOW_FC * CLK_PER_FC);
	localparam logic [10:0] STRETCH_CYC = 11'(STRETCH_FC * CLK_PER_FC);
	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// clock stop detector states
	typedef enum logic [1:0] {
		CS_OK    = 2'b00,
		CS_WAIT1 = 2'b01,
		CS_WAIT2 = 2'b11,
		CS_RST   = 2'b10
	} rscd_stop_t;
endpackage

// >>> testbench/test_reset_sources_clock_stop_detect.sv
// self-checking bench for the reset sources and clock stop detector
`timescale 1ns/1ps
`default_nettype none
module test_reset_sources_clock_stop_detect;
	import rscd_pkg::*;
	typedef struct {
		logic [11:0] wi;
		logic [7:0]  wd;
		logic [3:0]  ws;
		logic [1:0]  wr;
		logic [11:0] ri;
		logic [7:0]  rd;
		logic [1:0]  rr;
	} rscd_row_t;
	logic              clk = 1'b0;
	logic              nrst;
	logic [AXI_AW-1:0] awaddr;
	logic              awvalid;
	logic              awready;
	logic [31:0]       wdata;
	logic [3:0]        wstrb;
	logic              wvalid;
	logic              wready;
	logic [1:0]        bresp;
	logic              bvalid;
	logic              bready;
	logic [AXI_AW-1:0] araddr;
	logic              arvalid;
	logic              arready;
	logic [31:0]       rdata;
	logic [1:0]        rresp;
	logic              rvalid;
	logic              rready;
	logic              resetPinN;
	logic              lowClkPin = 1'b0;
	logic              fetchValid;
	logic [15:0]       fetchAddr;
	logic              wdResetReq;
	logic              lowPowerEnter;
	logic              cpuReset;
	logic              bootFetch;
	logic [15:0]       bootAddr;
	logic              highOscEn;
	logic              lowOscEn;
	logic              sysClkSel;
	int                lowHalf;
	int                lowCnt = 0;
	int                num_errors = 0;
	int                checked = 0;
	int                hiRun = 0;
	int                hiLen = 0;
	int                n;
	logic [31:0]       d;
	logic [1:0]        r;
	// bounds are set before the last enable row; the first enable row must be dropped
	rscd_row_t rows [11] = '{
		'{IDX_FLAGS, 8'h00, 4'hf, RESP_OKAY, IDX_FLAGS, 8'h00, RESP_OKAY},
		'{IDX_CTRL, 8'h12, 4'hf, RESP_OKAY, IDX_CTRL, 8'h00, RESP_OKAY},
		'{IDX_CTRL, CTRL_ON, 4'hf, RESP_OKAY, IDX_CTRL, 8'h00, RESP_OKAY},
		'{IDX_LOWER, 8'h55, 4'h0, RESP_OKAY, IDX_LOWER, LOWER_RST, RESP_OKAY},
		'{IDX_UPPER, 8'h1e, 4'h0, RESP_OKAY, IDX_UPPER, UPPER_RST, RESP_OKAY},
		'{IDX_SYSCTL, SYSCTL_RST, 4'hf, RESP_OKAY, IDX_SYSCTL, SYSCTL_RST,
			RESP_OKAY},
		'{12'h100, 8'h5a, 4'hf, RESP_SLVERR, 12'h100, 8'h00, RESP_SLVERR},
		'{IDX_LOWER, 8'h0a, 4'hf, RESP_OKAY, IDX_LOWER, 8'h0a, RESP_OKAY},
		'{IDX_UPPER, 8'h1e, 4'hf, RESP_OKAY, IDX_UPPER, 8'h1e, RESP_OKAY},
		'{IDX_SYSCTL, 8'hc0, 4'hf, RESP_OKAY, IDX_SYSCTL, 8'hc0, RESP_OKAY},
		'{IDX_CTRL, CTRL_ON, 4'hf, RESP_OKAY, IDX_CTRL, CTRL_ON, RESP_OKAY}
	};

	rscd_reset_ctrl i_rscd_reset_ctrl (
		.clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .resetPinN, .lowClkPin,
		.fetchValid, .fetchAddr, .wdResetReq, .lowPowerEnter, .cpuReset,
		.bootFetch, .bootAddr, .highOscEn, .lowOscEn, .sysClkSel
	);

	always #50 clk = ~clk;

	// low clock made from clk; a zero half period freezes it
	always @(posedge clk) begin
		if (lowHalf != 0) begin
			if (lowCnt + 1 >= lowHalf) begin
				lowCnt <= 0;
				lowClkPin <= ~lowClkPin;
			end else
				lowCnt <= lowCnt + 1;
		end
	end

	// length of each reset pulse, taken when it ends
	always @(negedge clk) begin
		if (cpuReset === 1'b1)
			hiRun <= hiRun + 1;
		else if (hiRun != 0) begin
			hiLen <= hiRun;
			hiRun <= 0;
		end
	end

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic time_out();
		num_errors++;
		$display("mismatch at %0t: wait ran out", $time);
		wrap_up();
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic bus_wr(input logic [11:0] idx, input logic [7:0] v,
			input logic [3:0] s, output logic [1:0] rsp);
		logic a;
		logic w;
		logic done;
		@(posedge clk);
		awaddr <= {idx, 2'b00};
		wdata <= 32'(v);
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		done = 1'b0;
		for (int k = 0; k < 40 && !done; k++) begin
			@(negedge clk);
			a = (awvalid & awready) === 1'b1;
			w = (wvalid & wready) === 1'b1;
			done = (bvalid & bready) === 1'b1;
			rsp = bresp;
			@(posedge clk);
			if (a) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			if (done) bready <= 1'b0;
		end
		if (!done) time_out();
	endtask

	task automatic bus_rd(input logic [11:0] idx, output logic [31:0] v,
			output logic [1:0] rsp);
		logic a;
		logic done;
		@(posedge clk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		done = 1'b0;
		for (int k = 0; k < 40 && !done; k++) begin
			@(negedge clk);
			a = (arvalid & arready) === 1'b1;
			done = (rvalid & rready) === 1'b1;
			v = rdata;
			rsp = rresp;
			@(posedge clk);
			if (a) arvalid <= 1'b0;
			if (done) rready <= 1'b0;
		end
		if (!done) time_out();
	endtask

	task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp);
		bus_rd(idx, d, r);
		check(d, 32'(exp));
		check(32'(r), 32'(RESP_OKAY));
	endtask

	task automatic wait_rst(input logic lvl, input int bound, output int c);
		for (c = 0; c < bound; c++) begin
			@(negedge clk);
			if (cpuReset === lvl) break;
		end
		if (c >= bound) time_out();
	endtask

	// kind 0 fetch, 1 watchdog request, 2 low power entry
	task automatic pulse(input int kind, input logic [15:0] a);
		@(posedge clk);
		fetchAddr <= a;
		fetchValid <= (kind == 0);
		wdResetReq <= (kind == 1);
		lowPowerEnter <= (kind == 2);
		@(posedge clk);
		fetchValid <= 1'b0;
		wdResetReq <= 1'b0;
		lowPowerEnter <= 1'b0;
	endtask

	task automatic expect_rst(input logic exp);
		int c;
		if (exp) begin
			wait_rst(1'b1, 30, c);
			check(32'(c < MAL_MAX_FC), 32'd1);
			wait_rst(1'b0, 1100, c);
			check(32'(bootFetch), 32'd1);
			check(32'(bootAddr), 32'(VECTOR_ADDR));
			@(negedge clk);
			check(32'(bootFetch), 32'd0);
			check(32'(hiLen), 32'(STRETCH_CYC));
		end else begin
			repeat (30) @(negedge clk);
			check(32'(cpuReset), 32'd0);
		end
	endtask

	initial begin
		nrst = 1'b0;
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		resetPinN = 1'b1;
		{fetchValid, fetchAddr, wdResetReq, lowPowerEnter} = '0;
		lowHalf = 40;
		repeat (20) @(posedge clk);
		check(32'({cpuReset, highOscEn, lowOscEn, sysClkSel, awready,
			arready, bvalid, rvalid}), 32'h0000_00cc);
		nrst <= 1'b1;
		wait_rst(1'b0, 1100, n);
		$display("test reset done");
		foreach (rows[i]) begin
			bus_wr(rows[i].wi, rows[i].wd, rows[i].ws, r);
			check(32'(r), 32'(rows[i].wr));
			bus_rd(rows[i].ri, d, r);
			check(d, 32'(rows[i].rd));
			check(32'(r), 32'(rows[i].rr));
		end
		bus_wr(IDX_LOWER, 8'h33, 4'hf, r);
		rd_chk(IDX_LOWER, 8'h0a);
		$display("test register rows done");
		// ratio 20 lies inside 10..30, ratio 50 does not
		repeat (600) @(negedge clk);
		check(32'(cpuReset), 32'd0);
		lowHalf = 100;
		wait_rst(1'b1, 1500, n);
		rd_chk(IDX_CTRL, CTRL_ON);
		rd_chk(IDX_FLAGS, 8'h01);
		check(32'(lowOscEn), 32'd1);
		lowHalf = 40;
		wait_rst(1'b0, 3000, n);
		lowHalf = 0;
		repeat (1500) @(negedge clk);
		check(32'(cpuReset), 32'd0);
		lowHalf = 40;
		wait_rst(1'b1, 400, n);
		wait_rst(1'b0, 3000, n);
		$display("test clock stop done");
		pulse(2, 16'h0000);
		rd_chk(IDX_CTRL, CTRL_OFF);
		bus_wr(IDX_CTRL, CTRL_ON, 4'hf, r);
		bus_wr(IDX_CTRL, CTRL_OFF, 4'hf, r);
		rd_chk(IDX_CTRL, CTRL_OFF);
		bus_wr(IDX_CTRL, CTRL_ON, 4'hf, r);
		bus_wr(IDX_SYSCTL, 8'h40, 4'hf, r);
		expect_rst(1'b1);
		rd_chk(IDX_CTRL, CTRL_ON);
		check(32'(highOscEn), 32'd1);
		bus_wr(IDX_SYSCTL, 8'h00, 4'hf, r);
		expect_rst(1'b1);
		bus_wr(IDX_SYSCTL, 8'he0, 4'hf, r);
		expect_rst(1'b0);
		bus_wr(IDX_SYSCTL, 8'ha0, 4'hf, r);
		expect_rst(1'b1);
		rd_chk(IDX_SYSCTL, 8'he0);
		check(32'(sysClkSel), 32'd1);
		// high enable cleared on the low clock is legal and stops detection
		bus_wr(IDX_SYSCTL, 8'h60, 4'hf, r);
		expect_rst(1'b0);
		rd_chk(IDX_CTRL, CTRL_OFF);
		check(32'(highOscEn), 32'd0);
		bus_wr(IDX_SYSCTL, 8'he0, 4'hf, r);
		bus_wr(IDX_SYSCTL, 8'hc0, 4'hf, r);
		$display("test system clock done");
		pulse(0, 16'h0010);
		expect_rst(1'b1);
		pulse(0, 16'h0f90);
		expect_rst(1'b1);
		pulse(0, 16'h0100);
		expect_rst(1'b0);
		bus_wr(IDX_SYSCTL, 8'hc1, 4'hf, r);
		pulse(0, 16'h0100);
		expect_rst(1'b1);
		pulse(1, 16'h0000);
		expect_rst(1'b1);
		rd_chk(IDX_FLAGS, 8'h0f);
		bus_wr(IDX_FLAGS, 8'h80, 4'hf, r);
		rd_chk(IDX_FLAGS, 8'h00);
		$display("test internal resets done");
		pulse(1, 16'h0000);
		expect_rst(1'b1);
		bus_wr(IDX_CTRL, CTRL_ON, 4'hf, r);
		// a low pulse shorter than twelve cycles must not reset
		@(posedge clk);
		resetPinN <= 1'b0;
		repeat (8) @(posedge clk);
		resetPinN <= 1'b1;
		expect_rst(1'b0);
		rd_chk(IDX_CTRL, CTRL_ON);
		@(posedge clk);
		resetPinN <= 1'b0;
		repeat (20) @(posedge clk);
		resetPinN <= 1'b1;
		wait_rst(1'b0, 1200, n);
		rd_chk(IDX_FLAGS, 8'h00);
		rd_chk(IDX_CTRL, CTRL_OFF);
		rd_chk(IDX_LOWER, LOWER_RST);
		rd_chk(IDX_UPPER, UPPER_RST);
		rd_chk(IDX_SYSCTL, SYSCTL_RST);
		$display("test pin reset done");
		wrap_up();
	end
endmodule
`default_nettype wire
